// ---- rtl/clock_decim_pkg.sv ----
// constants, layouts and types of the output clock and decimation configuration bank
// Operation
// - output clock skew follows two-bit delay field
// - bit 7 selects weak output drive
// - serial clock input needs both enable bits
// - bit 4 powers output clock buffer, resets one
// - bit 3 gives single-edge double-rate clocking
// - 20-bit frame pattern over three byte registers
// - bypass mode substitutes automatic frame pattern
// - bit 2 routes data through feature path
// - bit 1 enables downconverter, only with bit 2 set
// - three-bit ratio field sets decimation factor
// - bit 3 selects real low-pass decimation
// - bit 0 inverts oscillator phase
`default_nettype none
package clock_decim_pkg;
  // ****************************************************
  // register indices (byte address is four times index)
  // ****************************************************
  localparam int NUM_SLOTS = 9;
  localparam logic [5:0] SERIAL_SETUP_IDX = 6'h18;
  localparam logic [5:0] OUT_CLOCK_DELAY_IDX = 6'h1E;
  localparam logic [5:0] OUT_CLOCK_CONTROL_IDX = 6'h1F;
  localparam logic [5:0] FRAME_PATTERN_LOW_IDX = 6'h20;
  localparam logic [5:0] FRAME_PATTERN_MID_IDX = 6'h21;
  localparam logic [5:0] FRAME_PATTERN_HIGH_IDX = 6'h22;
  localparam logic [5:0] DIGITAL_PATH_ENABLE_IDX = 6'h24;
  localparam logic [5:0] DECIMATION_SETUP_IDX = 6'h25;
  localparam logic [5:0] CHANNEL_A_MIXER_IDX = 6'h26;
  localparam logic [5:0] BANK_STATUS_IDX = 6'h30;
  // slot numbers inside the storage array
  localparam logic [3:0] SLOT_SERIAL = 4'h0;
  localparam logic [3:0] SLOT_DELAY = 4'h1;
  localparam logic [3:0] SLOT_CONTROL = 4'h2;
  localparam logic [3:0] SLOT_PAT_LOW = 4'h3;
  localparam logic [3:0] SLOT_PAT_MID = 4'h4;
  localparam logic [3:0] SLOT_PAT_HIGH = 4'h5;
  localparam logic [3:0] SLOT_PATH = 4'h6;
  localparam logic [3:0] SLOT_DECIM = 4'h7;
  localparam logic [3:0] SLOT_MIXER = 4'h8;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  // ****************************************************
  // writable bit masks and reset values per slot
  // ****************************************************
  localparam logic [8:0][7:0] WRITE_MASK = {8'hF0, 8'h79, 8'h06, 8'h0F, 8'hFF, 8'hFF, 8'hD8, 8'h30, 8'h10};
  localparam logic [8:0][7:0] RESET_VALUE = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int SERIAL_CLKIN_BIT = 4;
  localparam int SKEW_LSB = 4;
  localparam int WEAK_DRIVE_BIT = 7;
  localparam int CLKIN_BIT = 6;
  localparam int OUT_BUF_BIT = 4;
  localparam int DOUBLE_RATE_BIT = 3;
  localparam int FEATURE_PATH_BIT = 2;
  localparam int DOWNCONVERTER_ENABLE_BIT = 1;
  localparam int RATIO_LSB = 4;
  localparam int REAL_DECIM_BIT = 3;
  localparam int PHASE_INV_BIT = 0;
  localparam int STAT_BYPASS_BIT = 0;
  localparam int STAT_RATIO_BAD_BIT = 1;
  localparam int STAT_CLKIN_BIT = 2;
  localparam int STAT_MIX_BIT = 3;
  localparam int MIX_QUARTER_BIT = 4;
  localparam int MIX_RELOAD_BIT = 5;
  localparam int MIX_GAIN_LSB = 6;
  // ****************************************************
  // output clock skew in ps (negative is advance)
  // ****************************************************
  localparam logic signed [7:0] SKEW_NONE_PS = 8'sh00;
  localparam logic signed [7:0] SKEW_ADVANCE_PS = -8'sh32;
  localparam logic signed [7:0] SKEW_DELAY_PS = 8'sh32;
  localparam logic signed [7:0] SKEW_DELAY2_PS = 8'sh64;
  // ****************************************************
  // frame patterns used when decimation is bypassed
  // ****************************************************
  localparam logic [19:0] AUTO_PAT_14 = 20'hFE000;
  localparam logic [19:0] AUTO_PAT_16 = 20'hFF000;
  localparam logic [19:0] AUTO_PAT_18 = 20'hFF800;
  localparam logic [19:0] AUTO_PAT_20 = 20'hFFC00;
  // decimation factor reported while bypassed
  localparam logic [5:0] FACTOR_NONE = 6'h01;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    RES_14 = 2'b00,
    RES_16 = 2'b01,
    RES_18 = 2'b10,
    RES_20 = 2'b11
  } resolution_e;
  typedef enum logic [2:0] {
    RATIO_1 = 3'b000,
    RATIO_2 = 3'b001,
    RATIO_4 = 3'b010,
    RATIO_8 = 3'b011,
    RATIO_16 = 3'b100,
    RATIO_32 = 3'b101
  } ratio_e;
  typedef struct packed {
    logic signed [7:0] clockSkewPs;
    logic [1:0] outClockSkew;
    logic weakDriveSelect;
    logic serialClockInBufferOn;
    logic outClockBufferOn;
    logic doubleRateSingleEdge;
    logic [19:0] framePattern;
    logic featurePathSelect;
    logic downconverterEnable;
    logic [5:0] decimationFactor;
    logic realDecimation;
    logic complexMixOn;
    logic oscPhaseInvert;
    logic chanAQuarterRateMix;
    logic chanAOscillatorReload;
    logic [1:0] chanAMixGain;
  } cfg_s;
  // converter view while reset holds: buffer on, bypass, 14-bit auto pattern
  localparam cfg_s CFG_AT_RESET = '{outClockBufferOn: 1'b1, framePattern: AUTO_PAT_14, decimationFactor: FACTOR_NONE,
    default: '0};
endpackage
`default_nettype wire

// ---- rtl/frame_pattern_select.sv ----
// selection of the frame clock pattern that actually drives the frame clock
`default_nettype none
module frame_pattern_select (
  // programmed pattern and mode
  input wire logic [19:0] programmed,
  input wire logic bypassActive,
  input wire clock_decim_pkg::resolution_e resolution,
  // effective pattern
  output logic [19:0] effective
);
  import clock_decim_pkg::*;
  logic [19:0] autoPattern;
  // automatic pattern per output resolution
  assign autoPattern = (resolution == RES_14) ? AUTO_PAT_14 :
                       (resolution == RES_16) ? AUTO_PAT_16 :
                       (resolution == RES_18) ? AUTO_PAT_18 : AUTO_PAT_20;
  // bypass ignores the programmed pattern
  assign effective = bypassActive ? autoPattern : programmed;
endmodule
`default_nettype wire

// ---- rtl/output_clock_and_decimation_cfg.sv ----
// configuration bank for output clocking and digital decimation path, wishbone slave
`default_nettype none
module output_clock_and_decimation_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // wishbone classic slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // converter side
  input wire clock_decim_pkg::resolution_e outputResolution,
  output clock_decim_pkg::cfg_s cfg
);
  import clock_decim_pkg::*;

  // ****************************************************
  // address decoding
  // ****************************************************
  function automatic logic [3:0] slotOf(input logic [5:0] idx);
    case (idx)
      SERIAL_SETUP_IDX: slotOf = SLOT_SERIAL;
      OUT_CLOCK_DELAY_IDX: slotOf = SLOT_DELAY;
      OUT_CLOCK_CONTROL_IDX: slotOf = SLOT_CONTROL;
      FRAME_PATTERN_LOW_IDX: slotOf = SLOT_PAT_LOW;
      FRAME_PATTERN_MID_IDX: slotOf = SLOT_PAT_MID;
      FRAME_PATTERN_HIGH_IDX: slotOf = SLOT_PAT_HIGH;
      DIGITAL_PATH_ENABLE_IDX: slotOf = SLOT_PATH;
      DECIMATION_SETUP_IDX: slotOf = SLOT_DECIM;
      CHANNEL_A_MIXER_IDX: slotOf = SLOT_MIXER;
      default: slotOf = SLOT_NONE;
    endcase
  endfunction

  // skew field to picoseconds
  function automatic logic signed [7:0] skewPs(input logic [1:0] code);
    case (code)
      2'b00: skewPs = SKEW_NONE_PS;
      2'b01: skewPs = SKEW_ADVANCE_PS;
      2'b10: skewPs = SKEW_DELAY_PS;
      default: skewPs = SKEW_DELAY2_PS;
    endcase
  endfunction

  // ratio code to decimation factor, unused codes fall back to one
  function automatic logic [5:0] factorOf(input logic [2:0] code);
    case (code)
      RATIO_1: factorOf = 6'h01;
      RATIO_2: factorOf = 6'h02;
      RATIO_4: factorOf = 6'h04;
      RATIO_8: factorOf = 6'h08;
      RATIO_16: factorOf = 6'h10;
      RATIO_32: factorOf = 6'h20;
      default: factorOf = 6'h01;
    endcase
  endfunction

  // ****************************************************
  // bus request qualification
  // ****************************************************
  logic [7:0] slotReg [NUM_SLOTS];
  logic ackReg;
  logic [31:0] datOutReg;
  logic [31:0] datOutNext;
  wire request = wbCyc & wbStb & ~ackReg;
  wire [5:0] reqIdx = wbAdr[7:2];
  wire [3:0] reqSlot = slotOf(reqIdx);
  wire slotHit = (reqSlot != SLOT_NONE);
  wire statusHit = (reqIdx == BANK_STATUS_IDX);
  wire writeStrobe = request & wbWe & wbSel[0] & slotHit;

  // ****************************************************
  // register storage, reserved bits forced to zero
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : gSlot
      wire hitThis = writeStrobe & (reqSlot == 4'(g));
      wire [7:0] slotNext = wbDatIn[7:0] & WRITE_MASK[g];
      // one storage byte per configuration register
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          slotReg[g] <= RESET_VALUE[g];
        end else if (hitThis) begin
          slotReg[g] <= slotNext;
        end
      end
    end
  endgenerate

  // ****************************************************
  // derived configuration
  // ****************************************************
  wire [7:0] serialSetup = slotReg[SLOT_SERIAL];
  wire [7:0] delaySetup = slotReg[SLOT_DELAY];
  wire [7:0] controlSetup = slotReg[SLOT_CONTROL];
  wire [7:0] pathSetup = slotReg[SLOT_PATH];
  wire [7:0] decimSetup = slotReg[SLOT_DECIM];
  wire [7:0] mixerSetup = slotReg[SLOT_MIXER];
  wire [1:0] skewCode = delaySetup[SKEW_LSB +: 2];
  wire [2:0] ratioCode = decimSetup[RATIO_LSB +: 3];
  wire ratioBad = (ratioCode > RATIO_32);
  // frame pattern assembled across three bytes
  wire [19:0] programmedPattern = {slotReg[SLOT_PAT_HIGH][3:0], slotReg[SLOT_PAT_MID], slotReg[SLOT_PAT_LOW]};
  // path and decimation controls
  wire featureOn = pathSetup[FEATURE_PATH_BIT];
  wire ddcOn = featureOn & pathSetup[DOWNCONVERTER_ENABLE_BIT];
  wire realMode = decimSetup[REAL_DECIM_BIT];
  wire bypassActive = ~ddcOn | (ratioCode == RATIO_1) | ratioBad;
  wire mixOn = ~bypassActive & ~realMode;
  // serial clock input powered only with both enables
  wire clkInOn = controlSetup[CLKIN_BIT] & serialSetup[SERIAL_CLKIN_BIT];
  wire [19:0] effectivePattern;
  cfg_s cfgNext;

  frame_pattern_select uPatSel (
    .programmed(programmedPattern),
    .bypassActive(bypassActive),
    .resolution(outputResolution),
    .effective(effectivePattern)
  );

  // ****************************************************
  // converter side outputs
  // ****************************************************
  assign cfgNext.clockSkewPs = skewPs(skewCode);
  assign cfgNext.outClockSkew = skewCode;
  assign cfgNext.weakDriveSelect = controlSetup[WEAK_DRIVE_BIT];
  assign cfgNext.serialClockInBufferOn = clkInOn;
  assign cfgNext.outClockBufferOn = controlSetup[OUT_BUF_BIT];
  assign cfgNext.doubleRateSingleEdge = controlSetup[DOUBLE_RATE_BIT];
  assign cfgNext.framePattern = effectivePattern;
  assign cfgNext.featurePathSelect = featureOn;
  assign cfgNext.downconverterEnable = ddcOn;
  assign cfgNext.decimationFactor = bypassActive ? FACTOR_NONE : factorOf(ratioCode);
  assign cfgNext.realDecimation = ~bypassActive & realMode;
  assign cfgNext.complexMixOn = mixOn;
  assign cfgNext.oscPhaseInvert = decimSetup[PHASE_INV_BIT];
  assign cfgNext.chanAQuarterRateMix = mixerSetup[MIX_QUARTER_BIT];
  assign cfgNext.chanAOscillatorReload = mixerSetup[MIX_RELOAD_BIT];
  assign cfgNext.chanAMixGain = mixerSetup[MIX_GAIN_LSB +: 2];

  // converter view held in flops, so the resolution input never ripples straight out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= CFG_AT_RESET;
    end else begin
      cfg <= cfgNext;
    end
  end

  // ****************************************************
  // read path
  // ****************************************************
  wire [7:0] statusByte = {4'h0, mixOn, clkInOn, ratioBad, bypassActive};
  wire [7:0] readByte = slotHit ? slotReg[slotHit ? reqSlot : SLOT_SERIAL] : (statusHit ? statusByte : 8'h00);
  assign datOutNext = (request & ~wbWe) ? {24'h000000, readByte} : datOutReg;

  // ack one cycle after request, dropped in the following cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
      datOutReg <= 32'h00000000;
    end else begin
      ackReg <= request;
      datOutReg <= datOutNext;
    end
  end

  assign wbAck = ackReg;
  assign wbDatOut = datOutReg;
endmodule
`default_nettype wire

// ---- tb/clk_decim_chk.sv ----
// port assertions for the clock and decimation bank
`default_nettype none
module clk_decim_chk import clock_decim_pkg::*; (
  // clock, reset and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  // converter side
  input wire clock_decim_pkg::resolution_e outputResolution,
  input wire clock_decim_pkg::cfg_s cfg
);
  // ***
  // accepted write decode
  // ***
  logic wr;
  logic [5:0] idx;
  assign wr = wbCyc && wbStb && !wbAck && wbWe && wbSel[0];
  assign idx = wbAdr[7:2];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ***
  // assertions
  // ***
  chk_ack_pulse: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("ack is not a one cycle pulse");
  chk_skew_map: assert property (
    cfg.clockSkewPs == (cfg.outClockSkew == 2'h0 ? 8'sh00 : cfg.outClockSkew == 2'h1 ? -8'sh32 :
    cfg.outClockSkew == 2'h2 ? 8'sh32 : 8'sh64)) else $error("skew value wrong");
  chk_weak_drive: assert property (
    wr && idx == 6'h1F |-> ##2 cfg.weakDriveSelect == $past(wbDatIn[7], 2)) else $error("drive bit wrong");
  chk_buffer_on: assert property (
    wr && idx == 6'h1F |-> ##2 cfg.outClockBufferOn == $past(wbDatIn[4], 2) &&
    cfg.doubleRateSingleEdge == $past(wbDatIn[3], 2)) else $error("buffer or rate bit wrong");
  chk_clkin_gate: assert property (
    wr && ((idx == 6'h1F && !wbDatIn[6]) || (idx == 6'h18 && !wbDatIn[4]))
    |-> ##2 !cfg.serialClockInBufferOn) else $error("clock input on with one bit clear");
  chk_auto_pattern: assert property (
    !cfg.featurePathSelect && $past(rst_b) |-> cfg.framePattern == (
    $past(outputResolution) == RES_14 ? 20'hFE000 : $past(outputResolution) == RES_16 ? 20'hFF000 :
    $past(outputResolution) == RES_18 ? 20'hFF800 : 20'hFFC00))
    else $error("bypass pattern wrong");
  chk_path_gate: assert property (
    cfg.downconverterEnable || cfg.realDecimation || cfg.complexMixOn |-> cfg.featurePathSelect)
    else $error("decimation active while bypassed");
  chk_ratio_range: assert property (
    cfg.realDecimation || cfg.complexMixOn |-> !(cfg.realDecimation && cfg.complexMixOn) &&
    cfg.decimationFactor inside {6'h02, 6'h04, 6'h08, 6'h10, 6'h20}) else $error("ratio wrong");
  chk_phase_inv: assert property (
    wr && idx == 6'h25 |-> ##2 cfg.oscPhaseInvert == $past(wbDatIn[0], 2)) else $error("phase bit wrong");
  // ***
  // covers
  // ***
  cover property (wr && idx == 6'h1F);
  cover property (cfg.realDecimation);
  cover property (cfg.complexMixOn && cfg.oscPhaseInvert);
endmodule
bind output_clock_and_decimation_cfg clk_decim_chk u_chk (.clk, .rst_b, .wbCyc, .wbStb, .wbWe,
  .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .outputResolution, .cfg);
`default_nettype wire

// ---- tb/tb_output_clock_and_decimation_cfg.sv ----
// self-checking bench of the clock and decimation bank
`default_nettype none
module tb_output_clock_and_decimation_cfg import clock_decim_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // stimulus, rows and dut
  // ***
  typedef struct packed {logic [7:0] adr; logic [7:0] wd; logic [7:0] ex;} row_s;
  row_s rows [11] = '{'{8'h60, 8'hFF, 8'h10}, '{8'h78, 8'hFF, 8'h30}, '{8'h7C, 8'hFF, 8'hD8},
    '{8'h80, 8'hA5, 8'hA5}, '{8'h84, 8'h5A, 8'h5A}, '{8'h88, 8'hFF, 8'h0F}, '{8'h90, 8'hFF, 8'h06},
    '{8'h94, 8'hFF, 8'h79}, '{8'h98, 8'hFF, 8'hF0}, '{8'hA0, 8'hFF, 8'h00}, '{8'hC0, 8'hFF, 8'h07}};
  logic [31:0] skew [4] = '{32'h0, 32'hFFFFFFCE, 32'h32, 32'h64};
  logic [19:0] auto [4] = '{20'hFE000, 20'hFF000, 20'hFF800, 20'hFFC00};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0;
  logic [31:0] wbDatOut;
  logic [31:0] rd;
  logic wbAck;
  resolution_e res = RES_14;
  cfg_s cfg;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  output_clock_and_decimation_cfg dut (.clk(clk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .outputResolution(res), .cfg(cfg));
  initial begin
    forever #5 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  // ***
  // tasks
  // ***
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check_read(input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      fail_count++;
      $display("ERROR %0t read %h expected %h", $time, got, ex);
    end
  endtask
  task automatic check_field(input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      fail_count++;
      $display("ERROR %0t field %h expected %h", $time, got, ex);
    end
  endtask
  // one classic cycle, ack and read data taken at the same rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatIn <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  // ***
  // sequence
  // ***
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd, 4'h1);
      wb(1'b0, rows[i].adr, 8'h00, 4'h1);
      check_read(rd, {24'h0, rows[i].ex});
    end
    wb(1'b1, 8'h80, 8'h33, 4'hE);
    wb(1'b0, 8'h80, 8'h00, 4'h1);
    check_read(rd, 32'hA5);
    $display("masks done");
    check_field({cfg.chanAMixGain, cfg.chanAOscillatorReload, cfg.chanAQuarterRateMix}, 32'hF);
    check_field({cfg.weakDriveSelect, cfg.serialClockInBufferOn, cfg.outClockBufferOn,
      cfg.doubleRateSingleEdge}, 32'hF);
    wb(1'b1, 8'h7C, 8'h40, 4'h1);
    check_field({cfg.weakDriveSelect, cfg.serialClockInBufferOn, cfg.outClockBufferOn,
      cfg.doubleRateSingleEdge}, 32'h4);
    wb(1'b1, 8'h60, 8'h00, 4'h1);
    check_field(cfg.serialClockInBufferOn, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'h78, 8'(k << 4), 4'h1);
      check_field(32'(cfg.clockSkewPs), skew[k]);
      check_field(32'(cfg.outClockSkew), 32'(k));
    end
    $display("clocking done");
    wb(1'b1, 8'h80, 8'h00, 4'h1);
    wb(1'b1, 8'h84, 8'hE0, 4'h1);
    wb(1'b1, 8'h88, 8'h0F, 4'h1);
    wb(1'b1, 8'h90, 8'h06, 4'h1);
    for (int r = 1; r < 6; r++) begin
      wb(1'b1, 8'h94, 8'(r * 16 + 8), 4'h1);
      check_field({cfg.framePattern, cfg.decimationFactor, cfg.realDecimation, cfg.complexMixOn,
        cfg.downconverterEnable, cfg.featurePathSelect}, {2'b0, 20'hFE000, 6'(1 << r), 4'hB});
    end
    wb(1'b1, 8'h80, 8'hFF, 4'h1);
    wb(1'b1, 8'h84, 8'hFF, 4'h1);
    wb(1'b1, 8'h94, 8'h31, 4'h1);
    check_field({cfg.framePattern, cfg.decimationFactor, cfg.realDecimation, cfg.complexMixOn,
      cfg.oscPhaseInvert}, {3'h0, 20'hFFFFF, 6'h08, 3'h3});
    wb(1'b1, 8'h94, 8'h60, 4'h1);
    check_field({cfg.framePattern, cfg.decimationFactor}, {6'h0, 20'hFE000, 6'h01});
    wb(1'b1, 8'h90, 8'h02, 4'h1);
    for (int k = 0; k < 4; k++) begin
      res <= resolution_e'(k);
      repeat (2) @(posedge clk);
      check_field({cfg.framePattern, cfg.featurePathSelect, cfg.downconverterEnable},
        {10'h0, auto[k], 2'b0});
    end
    $display("decimation done");
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].adr, 8'h00, 4'h1);
      check_read(rd, (rows[i].adr == 8'h7C) ? 32'h10 : (rows[i].adr == 8'hC0) ? 32'h01 : 32'h0);
    end
    $display("reset done");
    complete_run();
  end
endmodule
`default_nettype wire
